// ---- include/sbsci_defs.svh ----
// sbsci_defs.svh: constants of the synchronous burst static ram command block
// assumes inclusion by the package and the design file by bare name
`ifndef SBSCI_DEFS_SVH
`define SBSCI_DEFS_SVH

// geometry: four bytes of nine bits per word
`define SBSCI_ADDR_W 10
`define SBSCI_BYTE_W 9
`define SBSCI_BYTES 4
`define SBSCI_DATA_W 36
`define SBSCI_DEPTH 1024

// burst counter on the two lowest address bits
`define SBSCI_BURST_W 2
`define SBSCI_BURST_LO 0
`define SBSCI_BURST_HI 1
`define SBSCI_BURST_RST 2'h0
`define SBSCI_BURST_STEP 2'h1

// sleep entry and wake timing, in clock cycles
`define SBSCI_SLEEP_CNT_W 2
`define SBSCI_SLEEP_ENTRY_CYCLES 2'h2
`define SBSCI_SLEEP_WAKE_CYCLES 2'h2
`define SBSCI_SLEEP_CNT_RST 2'h0
`define SBSCI_SLEEP_CNT_STEP 2'h1

`endif

// ---- include/sbsci_pkg.sv ----
// sbsci_pkg.sv: types of the synchronous burst static ram command block
// assumes sbsci_defs.svh is on the include path
`include "sbsci_defs.svh"

package sbsci_pkg;

	typedef enum logic [2:0] {
		BK_NONE = 3'b001,
		BK_READ = 3'b010,
		BK_WRITE = 3'b100
	} sbsci_burst_kind_type;

	typedef enum logic [3:0] {
		SL_AWAKE = 4'b0001,
		SL_ENTER = 4'b0010,
		SL_ASLEEP = 4'b0100,
		SL_WAKING = 4'b1000
	} sbsci_sleep_state_type;

	// one pipeline stage of an access
	typedef struct packed {
		logic rd;
		logic wr;
		logic cont;
		logic [`SBSCI_BYTES-1:0] bwe_n;
		logic [`SBSCI_ADDR_W-1:0] addr;
	} sbsci_stage_type;

endpackage

// ---- src/sbsci_core.sv ----
// sbsci_core.sv: command decode, burst counter, read/write pipelines, sleep and data pin control
// assumes all pins except sleep and output enable are synchronous to clk; straps tied to a rail
//
// What this block does
// - selected edge, load, write high: latch address, start read burst
// - output enable high: access still done, data pins stay floating
// - selected edge, load, write low, some byte enable low: start write burst
// - advance high continues current burst at counter address, ignoring write and selects
// - write low with all byte enables high writes nothing, pins float
// - load with any chip select inactive deselects and floats pins
// - clock enable high: edge ignored, all state held except the sleep sequencer, which keeps running
// - stall in pipelined read keeps driving; stall in write stays floating
// - drivers switch off by themselves during writes
// - two-bit burst counter advances on every continue cycle
// - counter wraps to loaded start after four addresses
// - burst order strap low: linear start plus n modulo four
// - burst order strap high: interleaved start xor n
// - pipeline strap low flow-through, high or open pipelined
// - sleep high: asleep after two cycles, state kept
// - sleep low: normal after two cycles of wake-up
// - asleep: deselected, inputs ignored, outputs floating
// - sleep input left open reads as awake
// - outputs floating during power-up
// - pipelined read data two cycles after the command
// - flow-through read data right after the address edge
`timescale 1ns/1ps
`include "sbsci_defs.svh"

module sbsci_core
	import sbsci_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clock_enable_n,
	input wire logic load_or_advance,
	input wire logic write_enable_n,
	input wire logic [`SBSCI_BYTES-1:0] byte_write_enable_n,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic burst_order_strap,
	input wire logic pipeline_strap_n,
	input wire logic [`SBSCI_ADDR_W-1:0] address,
	input wire logic [`SBSCI_DATA_W-1:0] dq_in,
	output logic [`SBSCI_DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	output logic sleeping
);

	function automatic logic [`SBSCI_BURST_W-1:0] burst_low(
		input logic [`SBSCI_BURST_W-1:0] start,
		input logic [`SBSCI_BURST_W-1:0] cnt,
		input logic interleaved
	);
		burst_low = interleaved ? (start ^ cnt) : (start + cnt);
	endfunction

	logic [`SBSCI_DATA_W-1:0] mem [0:`SBSCI_DEPTH-1];

	sbsci_burst_kind_type kind_q;
	sbsci_sleep_state_type sleep_q;
	logic [`SBSCI_SLEEP_CNT_W-1:0] sleep_cnt_q;
	logic [`SBSCI_ADDR_W-1:0] base_q;
	logic [`SBSCI_BURST_W-1:0] cnt_q;
	logic [`SBSCI_BURST_W-1:0] cnt_d;
	sbsci_stage_type s1_q;
	sbsci_stage_type s2_q;
	sbsci_stage_type s1_d;
	logic [`SBSCI_DATA_W-1:0] rd_q;
	logic [`SBSCI_DATA_W-1:0] out_q;
	logic out_valid_q;
	logic asleep;
	logic active;
	logic selected;
	logic flow_mode;
	logic any_byte;
	logic [`SBSCI_ADDR_W-1:0] cont_addr;
	sbsci_stage_type wr_stage;
	logic wr_now;
	logic [`SBSCI_BYTES-1:0] wr_mask_n;
	logic drive_read;

	// pull resistors live in the pads; here an open strap arrives already at its default level
	assign flow_mode = !pipeline_strap_n;
	assign asleep = (sleep_q == SL_ASLEEP);
	assign sleeping = asleep;
	// stall and sleep both freeze every register of the access path
	assign active = !clock_enable_n && !asleep;
	assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	assign any_byte = !(&byte_write_enable_n);
	assign cnt_d = cnt_q + `SBSCI_BURST_STEP;
	assign cont_addr = {base_q[`SBSCI_ADDR_W-1:`SBSCI_BURST_W],
		burst_low(base_q[`SBSCI_BURST_HI:`SBSCI_BURST_LO], cnt_d, burst_order_strap)};

	// command decode into the first stage
	always_comb begin
		s1_d = '0;
		if (!load_or_advance) begin
			s1_d.addr = address;
			s1_d.bwe_n = byte_write_enable_n;
			if (selected && write_enable_n) begin
				s1_d.rd = 1'b1;
			end else if (selected && any_byte) begin
				s1_d.wr = 1'b1;
			end
		end else begin
			// write enable and selects are not looked at while advancing
			s1_d.addr = cont_addr;
			s1_d.bwe_n = byte_write_enable_n;
			s1_d.cont = 1'b1;
			s1_d.rd = (kind_q == BK_READ);
			s1_d.wr = (kind_q == BK_WRITE) && any_byte;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			kind_q <= BK_NONE;
		end else if (active && !load_or_advance) begin
			if (!selected) begin
				kind_q <= BK_NONE;
			end else if (write_enable_n) begin
				kind_q <= BK_READ;
			end else if (any_byte) begin
				kind_q <= BK_WRITE;
			end else begin
				kind_q <= BK_NONE;
			end
		end
	end

	// a deselect-continue leaves kind at none, so nothing is accessed and pins float
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_q <= '0;
			cnt_q <= `SBSCI_BURST_RST;
		end else if (active) begin
			if (!load_or_advance) begin
				base_q <= address;
				cnt_q <= `SBSCI_BURST_RST;
			end else begin
				cnt_q <= cnt_d;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else if (active) begin
			s1_q <= s1_d;
			s2_q <= s1_q;
		end
	end

	// write data lands one edge after the stage-one edge in flow-through, two in pipelined
	assign wr_stage = flow_mode ? s1_q : s2_q;
	assign wr_now = active && wr_stage.wr;
	// continued beats take their byte enables from the data edge itself
	assign wr_mask_n = wr_stage.cont ? byte_write_enable_n : wr_stage.bwe_n;

	// the array has no reset; its contents survive sleep untouched
	always_ff @(posedge clk) begin
		if (wr_now) begin
			for (int b = 0; b < `SBSCI_BYTES; b++) begin
				if (!wr_mask_n[b]) begin
					mem[wr_stage.addr][b*`SBSCI_BYTE_W +: `SBSCI_BYTE_W] <=
						dq_in[b*`SBSCI_BYTE_W +: `SBSCI_BYTE_W];
				end
			end
		end
	end

	// no write-to-read bypass: a read of a word still in the late-write path sees old data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q <= '0;
		end else if (active && s1_d.rd) begin
			rd_q <= mem[s1_d.addr];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_q <= '0;
			out_valid_q <= 1'b0;
		end else if (active) begin
			out_q <= rd_q;
			out_valid_q <= s1_q.rd;
		end
	end

	// stall freezes the valid flags, so a read keeps driving and a write stays floating
	assign drive_read = flow_mode ? s1_q.rd : out_valid_q;
	assign dq_oe_n = !(drive_read && !output_enable_n && !asleep);
	assign dq_out = flow_mode ? rd_q : out_q;

	// sleep sequencer; an open sleep pin is pulled low and reads as awake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_q <= SL_AWAKE;
			sleep_cnt_q <= `SBSCI_SLEEP_CNT_RST;
		end else begin
			case (sleep_q)
				SL_AWAKE: begin
					if (sleep_request) begin
						sleep_q <= SL_ENTER;
						sleep_cnt_q <= `SBSCI_SLEEP_CNT_STEP;
					end
				end
				SL_ENTER: begin
					if (!sleep_request) begin
						sleep_q <= SL_AWAKE;
						sleep_cnt_q <= `SBSCI_SLEEP_CNT_RST;
					end else if (sleep_cnt_q + `SBSCI_SLEEP_CNT_STEP == `SBSCI_SLEEP_ENTRY_CYCLES) begin
						sleep_q <= SL_ASLEEP;
						sleep_cnt_q <= `SBSCI_SLEEP_CNT_RST;
					end else begin
						sleep_cnt_q <= sleep_cnt_q + `SBSCI_SLEEP_CNT_STEP;
					end
				end
				SL_ASLEEP: begin
					if (!sleep_request) begin
						sleep_q <= SL_WAKING;
						sleep_cnt_q <= `SBSCI_SLEEP_CNT_STEP;
					end
				end
				SL_WAKING: begin
					if (sleep_request) begin
						sleep_q <= SL_ASLEEP;
						sleep_cnt_q <= `SBSCI_SLEEP_CNT_RST;
					end else if (sleep_cnt_q + `SBSCI_SLEEP_CNT_STEP == `SBSCI_SLEEP_WAKE_CYCLES) begin
						sleep_q <= SL_AWAKE;
						sleep_cnt_q <= `SBSCI_SLEEP_CNT_RST;
					end else begin
						sleep_cnt_q <= sleep_cnt_q + `SBSCI_SLEEP_CNT_STEP;
					end
				end
				default: begin
					sleep_q <= SL_AWAKE;
					sleep_cnt_q <= `SBSCI_SLEEP_CNT_RST;
				end
			endcase
		end
	end

	property p_read_begin;
		@(posedge clk) disable iff (rst)
		active && !load_or_advance && selected && write_enable_n
		|=> s1_q.rd && !s1_q.wr && s1_q.addr == $past(address) && kind_q == BK_READ;
	endproperty
	a_read_begin: assert property (p_read_begin) else $error("read begin not latched");

	property p_write_begin;
		@(posedge clk) disable iff (rst)
		active && !load_or_advance && selected && !write_enable_n && any_byte
		|=> s1_q.wr && !s1_q.rd && kind_q == BK_WRITE;
	endproperty
	a_write_begin: assert property (p_write_begin) else $error("write begin not latched");

	property p_abort;
		@(posedge clk) disable iff (rst)
		active && !write_enable_n && !any_byte && (load_or_advance ? kind_q != BK_READ : selected)
		|=> !s1_q.wr && !s1_q.rd;
	endproperty
	a_abort: assert property (p_abort) else $error("aborted write still queued");

	property p_deselect;
		@(posedge clk) disable iff (rst)
		active && !load_or_advance && !selected
		|=> kind_q == BK_NONE && !s1_q.rd && !s1_q.wr;
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect did not idle");

	property p_stall_hold;
		@(posedge clk) disable iff (rst)
		clock_enable_n
		|=> $stable(cnt_q) && $stable(s1_q) && $stable(kind_q) && $stable(base_q) && $stable(dq_out);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("state moved on a stalled edge");

	property p_write_floats;
		@(posedge clk) disable iff (rst)
		wr_stage.wr |-> dq_oe_n;
	endproperty
	a_write_floats: assert property (p_write_floats) else $error("data pins driven without a read");

	property p_wrap;
		@(posedge clk) disable iff (rst)
		(active && load_or_advance)[*4] |=> cnt_q == $past(cnt_q, 4);
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst counter did not wrap after four");

	property p_linear;
		@(posedge clk) disable iff (rst)
		active && load_or_advance && !burst_order_strap
		|=> s1_q.addr[`SBSCI_BURST_HI:`SBSCI_BURST_LO] == base_q[`SBSCI_BURST_HI:`SBSCI_BURST_LO] + cnt_q;
	endproperty
	a_linear: assert property (p_linear) else $error("linear burst address wrong");

	property p_interleave;
		@(posedge clk) disable iff (rst)
		active && load_or_advance && burst_order_strap
		|=> s1_q.addr[`SBSCI_BURST_HI:`SBSCI_BURST_LO] == (base_q[`SBSCI_BURST_HI:`SBSCI_BURST_LO] ^ cnt_q);
	endproperty
	a_interleave: assert property (p_interleave) else $error("interleaved burst address wrong");

	property p_sleep_entry;
		@(posedge clk) disable iff (rst)
		(sleep_q == SL_AWAKE && sleep_request) ##1 sleep_request |=> sleeping ##0 dq_oe_n;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered after two cycles");

	property p_wake;
		@(posedge clk) disable iff (rst)
		(sleep_q == SL_ASLEEP && !sleep_request) ##1 !sleep_request |=> sleep_q == SL_AWAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake-up not complete after two cycles");

	property p_pipe_latency;
		@(posedge clk) disable iff (rst)
		active && !flow_mode && s1_d.rd ##1 active && !output_enable_n && !flow_mode && !asleep
		|=> !dq_oe_n && dq_out == $past(rd_q);
	endproperty
	a_pipe_latency: assert property (p_pipe_latency) else $error("pipelined read data late");

	property p_flow_latency;
		@(posedge clk) disable iff (rst)
		active && flow_mode && s1_d.rd
		|=> (output_enable_n || asleep || !dq_oe_n) && dq_out == $past(mem[s1_d.addr]);
	endproperty
	a_flow_latency: assert property (p_flow_latency) else $error("flow-through read data late");

endmodule // sbsci_core

// ---- tb/sbsci_ctrl_model.sv ----
// sbsci_ctrl_model.sv: controller side of the late-write data path
// assumes the bench hands write data with each command it drives
`timescale 1ns/1ps
`include "sbsci_defs.svh"
module sbsci_ctrl_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic clock_enable_n,
	input wire logic sleeping,
	input wire logic pipeline_strap_n,
	input wire logic wvalid,
	input wire logic [`SBSCI_DATA_W-1:0] wdata,
	output logic [`SBSCI_DATA_W-1:0] dq_in
);
	logic [`SBSCI_DATA_W-1:0] held_q;
	logic held_valid_q;
	// stall edges freeze the data phase; idle bus toggles so stale data never matches
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held_q <= '0;
			held_valid_q <= 1'b0;
			dq_in <= '0;
		end else if (!clock_enable_n && !sleeping) begin
			held_q <= wdata;
			held_valid_q <= wvalid;
			if (pipeline_strap_n) begin
				dq_in <= held_valid_q ? held_q : ~dq_in;
			end else begin
				dq_in <= wvalid ? wdata : ~dq_in;
			end
		end
	end
endmodule // sbsci_ctrl_model

// ---- tb/sync_burst_sram_command_interface_tb.sv ----
// sync_burst_sram_command_interface_tb.sv: self-checking bench of the command block
// assumes the controller model supplies late write data
`timescale 1ns/1ps
`include "sbsci_defs.svh"
module sync_burst_sram_command_interface_tb;
	logic clk = 1'b0;
	logic rst, clock_enable_n, load_or_advance, write_enable_n, output_enable_n, sleep_request;
	logic chip_select_first_n, chip_select_second, chip_select_third_n, burst_order_strap, pipeline_strap_n;
	logic [3:0] byte_write_enable_n;
	logic [9:0] address;
	logic [35:0] dq_in, dq_out, wdata;
	logic dq_oe_n, sleeping, wvalid;
	logic [35:0] exp_mem [0:7];
	int n_mismatch = 0;
	int n_checks = 0;
	// order, start, four beats of the low address bits
	logic [10:0] rows [8] = '{11'b0_00_00011011, 11'b0_01_01101100, 11'b0_10_10110001, 11'b0_11_11000110,
		11'b1_00_00011011, 11'b1_01_01001110, 11'b1_10_10110001, 11'b1_11_11100100};

	always #2 clk = ~clk;

	sbsci_core dut (.clk(clk), .rst(rst), .clock_enable_n(clock_enable_n), .load_or_advance(load_or_advance),
		.write_enable_n(write_enable_n), .byte_write_enable_n(byte_write_enable_n),
		.chip_select_first_n(chip_select_first_n), .chip_select_second(chip_select_second),
		.chip_select_third_n(chip_select_third_n), .output_enable_n(output_enable_n),
		.sleep_request(sleep_request), .burst_order_strap(burst_order_strap),
		.pipeline_strap_n(pipeline_strap_n), .address(address), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .sleeping(sleeping));
	sbsci_ctrl_model ctrl (.clk(clk), .rst(rst), .clock_enable_n(clock_enable_n), .sleeping(sleeping),
		.pipeline_strap_n(pipeline_strap_n), .wvalid(wvalid), .wdata(wdata), .dq_in(dq_in));

	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk_dq(input logic e_oe, input logic [35:0] e_d);
		n_checks++;
		if (dq_oe_n !== e_oe || (!e_oe && dq_out !== e_d)) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h/%h exp %h/%h", $time, dq_oe_n, dq_out, e_oe, e_d);
		end
	endtask

	task chk_bit(input logic got, input logic e);
		n_checks++;
		if (got !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
		end
	endtask

	// kinds: 0 deselect (select pattern from a[1:0]), 1 read, 2 write, 3 continue, 4 stall, 5 write continue
	task issue(input logic [2:0] k, input logic [9:0] a, input logic [3:0] be, input logic [35:0] d);
		logic bad;
		logic cont;
		bad = (k == 3'h0 || k == 3'h3);
		cont = (k == 3'h3 || k == 3'h5);
		@(posedge clk);
		clock_enable_n <= (k == 3'h4);
		load_or_advance <= cont;
		write_enable_n <= !(k == 3'h2 || cont);
		byte_write_enable_n <= be;
		chip_select_first_n <= bad && a[1:0] == 2'h0;
		chip_select_second <= !(bad && a[1:0] == 2'h1);
		chip_select_third_n <= bad && a[1:0] >= 2'h2;
		address <= cont ? ~a : a;
		wdata <= d;
		wvalid <= (k == 3'h2 || k == 3'h5);
		#1;
	endtask

	// expected array update: only bytes whose enable is low
	task put(input logic [9:0] a, input logic [3:0] be, input logic [35:0] d);
		for (int b = 0; b < 4; b++)
			if (!be[b])
				exp_mem[a[2:0]][9*b +: 9] = d[9*b +: 9];
	endtask

	task wr(input logic [9:0] a, input logic [3:0] be, input logic [35:0] d);
		issue(3'h2, a, be, d);
		put(a, be, d);
	endtask

	// read burst of five beats, fifth must repeat the start
	task rd_burst(input logic [9:0] a, input logic [7:0] seq);
		int lat;
		logic [9:0] w;
		lat = pipeline_strap_n ? 2 : 1;
		for (int k = 0; k < 5 + lat; k++) begin
			issue(k == 0 ? 3'h1 : (k < 5 ? 3'h3 : 3'h0), a, 4'hf, '0);
			if (k >= lat) begin
				w = {a[9:2], seq[7 - 2 * ((k - lat) % 4) -: 2]};
				chk_dq(1'b0, exp_mem[w[2:0]]);
			end
		end
	endtask

	initial begin
		{clock_enable_n, load_or_advance, write_enable_n, output_enable_n, sleep_request} = 5'b00100;
		{chip_select_first_n, chip_select_second, chip_select_third_n} = 3'b101;
		{burst_order_strap, pipeline_strap_n, byte_write_enable_n, address} = '0;
		{wdata, wvalid, rst} = '0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1 chk_dq(1'b1, '0);
		chk_bit(sleeping, 1'b0);
		for (int m = 0; m < 2; m++) begin
			@(posedge clk) pipeline_strap_n <= m[0];
			for (int i = 0; i < 8; i++)
				wr(i[9:0], 4'h0, 36'h123456789 + 36'(i * 2 + m) * 36'h111111111);
			for (int r = 0; r < 8; r++) begin
				@(posedge clk) burst_order_strap <= rows[r][10];
				rd_burst({8'h00, rows[r][9:8]}, rows[r][7:0]);
			end
			$display("test burst table mode %0d done", m);
		end
		// byte mask, abort and stalled write, with drivers off meanwhile
		wr(10'h1, 4'b1010, 36'hfffffffff);
		chk_dq(1'b1, '0);
		wr(10'h2, 4'hf, 36'h0);
		wr(10'h3, 4'h0, 36'h0abcdef12);
		issue(3'h4, 10'h0, 4'h0, '0);
		chk_dq(1'b1, '0);
		issue(3'h0, 10'h0, 4'hf, '0);
		issue(3'h0, 10'h0, 4'hf, '0);
		rd_burst(10'h0, 8'b00011011);
		$display("test write masks done");
		// continued write beats: enables of the data edge pick the bytes, an abort beat writes nothing
		issue(3'h2, 10'h4, 4'h0, 36'h0a1b2c3d4);
		issue(3'h5, 10'h4, 4'h0, 36'h155aa55aa);
		issue(3'h5, 10'h4, 4'hf, 36'h0ffff0000);
		issue(3'h5, 10'h4, 4'b1100, 36'h1234abcde);
		issue(3'h0, 10'h0, 4'b1110, '0);
		issue(3'h0, 10'h0, 4'b0111, '0);
		put(10'h4, 4'h0, 36'h0a1b2c3d4);
		put(10'h5, 4'b1100, 36'h155aa55aa);
		put(10'h7, 4'b0111, 36'h1234abcde);
		rd_burst(10'h4, 8'b00011011);
		$display("test write burst done");
		// stalled read keeps driving and holds the counter
		issue(3'h1, 10'h0, 4'hf, '0);
		issue(3'h3, 10'h0, 4'hf, '0);
		issue(3'h4, 10'h0, 4'hf, '0);
		chk_dq(1'b0, exp_mem[0]);
		issue(3'h3, 10'h0, 4'hf, '0);
		chk_dq(1'b0, exp_mem[0]);
		issue(3'h0, 10'h0, 4'hf, '0);
		chk_dq(1'b0, exp_mem[1]);
		issue(3'h0, 10'h0, 4'hf, '0);
		chk_dq(1'b0, exp_mem[2]);
		$display("test read stall done");
		@(posedge clk) output_enable_n <= 1'b1;
		issue(3'h1, 10'h1, 4'hf, '0);
		issue(3'h0, 10'h0, 4'hf, '0);
		issue(3'h0, 10'h0, 4'hf, '0);
		chk_dq(1'b1, '0);
		@(posedge clk) output_enable_n <= 1'b0;
		for (int j = 0; j < 3; j++) begin
			issue(3'h0, j[9:0], 4'hf, '0);
			issue(3'h3, 10'h0, 4'hf, '0);
			issue(3'h3, 10'h0, 4'hf, '0);
			chk_dq(1'b1, '0);
			issue(3'h0, 10'h0, 4'hf, '0);
			chk_dq(1'b1, '0);
		end
		$display("test deselect done");
		// sleep raised only with nothing pending; only deselects while recovering
		@(posedge clk) sleep_request <= 1'b1;
		issue(3'h0, 10'h0, 4'hf, '0);
		chk_bit(sleeping, 1'b0);
		issue(3'h0, 10'h0, 4'hf, '0);
		chk_bit(sleeping, 1'b1);
		for (int i = 0; i < 3; i++) begin
			issue(3'h1, 10'h0, 4'hf, '0);
			chk_dq(1'b1, '0);
		end
		issue(3'h0, 10'h0, 4'hf, '0);
		@(posedge clk) sleep_request <= 1'b0;
		issue(3'h0, 10'h0, 4'hf, '0);
		issue(3'h0, 10'h0, 4'hf, '0);
		chk_bit(sleeping, 1'b0);
		rd_burst(10'h0, 8'b00011011);
		$display("test sleep done");
		results();
	end

	initial begin
		#20000;
		n_mismatch++;
		results();
	end
endmodule // sync_burst_sram_command_interface_tb
